// >>> ctl_blocks_pkg.sv
// Functional notes
// - On-delay starts timing on trigger rising edge.
// - On-delay output rises after full delay.
// - On-delay trigger low forces output low.
// - Delays span 0.01 to 99.99 units.
// - Off-delay trigger high drives output high.
// - Off-delay falling edge starts timing, output high.
// - Off-delay expiry clears output, resets timer.
// - Each off-delay falling edge restarts timer.
// - Off-delay clear wins, resets timer, output low.
// - Toggle relay flips on trigger rising edge.
// - Toggle clear forces low, beats trigger.
// - Toggle relay starts low after power.
// - Switch holds 127 on/off intervals.
// - Switch output on when interval active.
// - Per-block date or weekday calendar select.
// - On/off interval: hold, on, then off.
// - On-only interval: hold before, on after.
// - Off-only interval: hold before, off after.
// - Week runs Monday to Sunday; start before end.
// - Weekday off-only acts on selected days only.
// - On time drives on, off time drives off.
package ctl_blocks_pkg;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_ON_DLY   = 8'h04;
   localparam logic [7:0] ADDR_OFF_DLY  = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_TIME     = 8'h10;
   localparam logic [7:0] ADDR_DATE     = 8'h14;
   localparam logic [7:0] ADDR_TBL_IDX  = 8'h18;
   localparam logic [7:0] ADDR_TBL_TIME = 8'h1c;
   localparam logic [7:0] ADDR_TBL_DAY  = 8'h20;
   // Delay values in hundredths of a unit.
   localparam int          DLY_W   = 14;
   localparam logic [13:0] DLY_MIN = 14'h0001;
   localparam logic [13:0] DLY_MAX = 14'h270f;
   // Time unit codes and the length of one hundredth of each unit in base ticks.
   localparam logic [1:0]  UNIT_SEC  = 2'h0;
   localparam logic [1:0]  UNIT_MIN  = 2'h1;
   localparam logic [1:0]  UNIT_HOUR = 2'h2;
   localparam int          PRE_W     = 12;
   localparam logic [11:0] PRE_SEC   = 12'h001;
   localparam logic [11:0] PRE_MIN   = 12'h03c;
   localparam logic [11:0] PRE_HOUR  = 12'he10;
   // Base tick of one hundredth of a second.
   localparam int TICK_PERIOD_NS  = 10_000_000;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W          = 20;
   // Real-time clock limits.
   localparam logic [6:0]  HUND_LAST = 7'h63;
   localparam logic [5:0]  SEC_LAST  = 6'h3b;
   localparam logic [10:0] MIN_LAST  = 11'h59f;
   localparam logic [2:0]  WDAY_LAST = 3'h6;
   // Interval table.
   localparam int         IDX_W     = 7;
   localparam int         N_SLOTS   = 127;
   localparam logic [6:0] SLOT_LAST = 7'h7e;
   // Synchronised input positions.
   localparam int N_IN        = 5;
   localparam int IN_ON_TRIG  = 0;
   localparam int IN_OFF_TRIG = 1;
   localparam int IN_OFF_CLR  = 2;
   localparam int IN_TOG_TRIG = 3;
   localparam int IN_TOG_CLR  = 4;

   typedef struct packed {
      logic [26:0] rsvd;
      logic        tod_week;
      logic [1:0]  off_unit;
      logic [1:0]  on_unit;
   } ctrl_t;

   typedef struct packed {
      logic [20:0] rsvd;
      logic [4:0]  in_lvl;
      logic        off_run;
      logic        on_run;
      logic        tod_q;
      logic        tog_q;
      logic        off_q;
      logic        on_q;
   } status_t;

   typedef struct packed {
      logic [12:0] rsvd;
      logic [2:0]  wday;
      logic [4:0]  rsvd2;
      logic [10:0] minute;
   } time_t;

   typedef struct packed {
      logic        on_en;
      logic        off_en;
      logic [7:0]  rsvd;
      logic [10:0] on_min;
      logic [10:0] off_min;
   } slot_time_t;

   typedef struct packed {
      logic [9:0]  rsvd;
      logic [2:0]  wday_end;
      logic [2:0]  wday_start;
      logic [15:0] date;
   } slot_day_t;

   typedef enum logic [0:0] {
      SCAN_IDLE = 1'b0,
      SCAN_RUN  = 1'b1
   } scan_state_t;
endpackage : ctl_blocks_pkg

// >>> ctl_blocks.sv
// Local design decisions: the register offsets and the APB interface to the registers.
module ctl_blocks
   import ctl_blocks_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        on_trig,
   input  wire logic        off_trig,
   input  wire logic        off_clr,
   input  wire logic        tog_trig,
   input  wire logic        tog_clr,
   output logic             on_delay_q,
   output logic             off_delay_q,
   output logic             toggle_q,
   output logic             tod_q
);

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // Length of one hundredth of the chosen unit, in base ticks, less one.
   function automatic logic [PRE_W-1:0] unit_pre(input logic [1:0] u);
      return ((u == UNIT_HOUR) ? PRE_HOUR : (u == UNIT_MIN) ? PRE_MIN : PRE_SEC) - PRE_W'(1);
   endfunction : unit_pre

   // Keeps a written delay inside the accepted range.
   function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] v);
      return (v > 32'(DLY_MAX)) ? DLY_MAX :
             (v < 32'(DLY_MIN)) ? DLY_MIN : v[DLY_W-1:0];
   endfunction : clamp_dly

   ctrl_t              ctrl_r;
   logic [DLY_W-1:0]   on_dly_r, off_dly_r;
   logic [IDX_W-1:0]   tbl_idx_r;
   logic [31:0]        prdata_r;
   logic [N_IN-1:0]    s1_r, s2_r, s3_r;
   logic [N_IN-1:0]    lvl_r, lvl_nxt, prev_r;
   logic [N_IN-1:0]    rise, fall;
   logic [TICK_W-1:0]  tick_cnt_r;
   logic               tick;
   logic [PRE_W-1:0]   on_pre_r, off_pre_r;
   logic [DLY_W-1:0]   on_cnt_r, off_cnt_r;
   logic               on_run_r, on_q_r, on_step;
   logic               off_run_r, off_q_r, off_step;
   logic [6:0]         hund_r;
   logic [5:0]         sec_r;
   logic [10:0]        min_r;
   logic [2:0]         wday_r;
   logic [15:0]        date_r;
   logic               tog_q_r, tod_q_r, min_evt_r;
   scan_state_t        scan_r;
   logic [IDX_W-1:0]   scan_idx_r;
   logic [N_SLOTS-1:0] slot_vld_r;
   slot_time_t         slot_time_mem [N_SLOTS];
   slot_day_t          slot_day_mem  [N_SLOTS];

   // Bus strobes and address decode.
   logic        wr_en, rd_setup, addr_hit, idx_ok;
   time_t       time_wr, time_rd;
   status_t     status;
   logic [31:0] rd_mux;

   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign idx_ok   = tbl_idx_r <= SLOT_LAST;
   assign time_wr  = time_t'(pwdata);
   assign addr_hit = (paddr == ADDR_CTRL) | (paddr == ADDR_ON_DLY) |
                     (paddr == ADDR_OFF_DLY) | (paddr == ADDR_STATUS) |
                     (paddr == ADDR_TIME) | (paddr == ADDR_DATE) |
                     (paddr == ADDR_TBL_IDX) | (paddr == ADDR_TBL_TIME) |
                     (paddr == ADDR_TBL_DAY);
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~addr_hit;
   assign prdata   = prdata_r;

   // Status and time words as software sees them.
   assign status = '{rsvd: '0, in_lvl: lvl_r, off_run: off_run_r,
                     on_run: on_run_r, tod_q: tod_q_r, tog_q: tog_q_r,
                     off_q: off_q_r, on_q: on_q_r};
   assign time_rd = '{rsvd: '0, wday: wday_r, rsvd2: '0, minute: min_r};

   // Read data selection.
   always_comb begin
      rd_mux = '0;
      if (paddr == ADDR_CTRL) begin
         rd_mux = 32'(ctrl_r);
      end else if (paddr == ADDR_ON_DLY) begin
         rd_mux = 32'(on_dly_r);
      end else if (paddr == ADDR_OFF_DLY) begin
         rd_mux = 32'(off_dly_r);
      end else if (paddr == ADDR_STATUS) begin
         rd_mux = 32'(status);
      end else if (paddr == ADDR_TIME) begin
         rd_mux = 32'(time_rd);
      end else if (paddr == ADDR_DATE) begin
         rd_mux = 32'(date_r);
      end else if (paddr == ADDR_TBL_IDX) begin
         rd_mux = 32'(tbl_idx_r);
      end else if (paddr == ADDR_TBL_TIME && idx_ok) begin
         rd_mux = 32'(slot_time_mem[tbl_idx_r]);
      end else if (paddr == ADDR_TBL_DAY && idx_ok) begin
         rd_mux = 32'(slot_day_mem[tbl_idx_r]);
      end
   end

   // Configuration registers, written in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= '0;
         on_dly_r  <= DLY_MIN;
         off_dly_r <= DLY_MIN;
         tbl_idx_r <= '0;
         prdata_r  <= '0;
      end else begin
         if (rd_setup) begin
            prdata_r <= rd_mux;
         end
         if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_r <= '{rsvd: '0, tod_week: pwdata[4], off_unit: pwdata[3:2],
                        on_unit: pwdata[1:0]};
         end
         if (wr_en && paddr == ADDR_ON_DLY) begin
            on_dly_r <= clamp_dly(pwdata);
         end
         if (wr_en && paddr == ADDR_OFF_DLY) begin
            off_dly_r <= clamp_dly(pwdata);
         end
         if (wr_en && paddr == ADDR_TBL_IDX) begin
            tbl_idx_r <= pwdata[IDX_W-1:0];
         end
      end
   end

   // Interval table storage; a slot counts once its time word is written.
   always_ff @(posedge pclk) begin
      if (wr_en && idx_ok && paddr == ADDR_TBL_TIME) begin
         slot_time_mem[tbl_idx_r] <= slot_time_t'(pwdata);
      end
      if (wr_en && idx_ok && paddr == ADDR_TBL_DAY) begin
         slot_day_mem[tbl_idx_r] <= slot_day_t'(pwdata);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_vld_r <= '0;
      end else if (wr_en && idx_ok && paddr == ADDR_TBL_TIME) begin
         slot_vld_r[tbl_idx_r] <= 1'b1;
      end
   end

   // Pin inputs: three stages, a level counts when stages two and three agree.
   assign lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
   assign rise    = lvl_r & ~prev_r;
   assign fall    = ~lvl_r & prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         lvl_r  <= '0;
         prev_r <= '0;
      end else begin
         s1_r   <= {tog_clr, tog_trig, off_clr, off_trig, on_trig};
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         lvl_r  <= lvl_nxt;
         prev_r <= lvl_r;
      end
   end

   // Base tick, one pulse every hundredth of a second.
   assign tick = tick_cnt_r == TICK_LAST;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
      end
   end

   // A timer step is one hundredth of its unit.
   assign on_step  = tick && on_pre_r == unit_pre(ctrl_r.on_unit);
   assign off_step = tick && off_pre_r == unit_pre(ctrl_r.off_unit);

   // On-delay timer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_pre_r <= '0;
         on_cnt_r <= '0;
         on_run_r <= 1'b0;
         on_q_r   <= 1'b0;
      end else if (!lvl_r[IN_ON_TRIG]) begin
         on_pre_r <= '0;
         on_cnt_r <= '0;
         on_run_r <= 1'b0;
         on_q_r   <= 1'b0;
      end else if (rise[IN_ON_TRIG]) begin
         on_pre_r <= '0;
         on_cnt_r <= '0;
         on_run_r <= 1'b1;
      end else if (on_run_r && on_step) begin
         on_pre_r <= '0;
         on_cnt_r <= on_cnt_r + DLY_W'(1);
         if (on_cnt_r + DLY_W'(1) == on_dly_r) begin
            on_run_r <= 1'b0;
            on_q_r   <= 1'b1;
         end
      end else if (on_run_r && tick) begin
         on_pre_r <= on_pre_r + PRE_W'(1);
      end
   end

   // Off-delay timer; clear beats trigger.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_pre_r <= '0;
         off_cnt_r <= '0;
         off_run_r <= 1'b0;
         off_q_r   <= 1'b0;
      end else if (lvl_r[IN_OFF_CLR]) begin
         off_pre_r <= '0;
         off_cnt_r <= '0;
         off_run_r <= 1'b0;
         off_q_r   <= 1'b0;
      end else if (lvl_r[IN_OFF_TRIG]) begin
         off_run_r <= 1'b0;
         off_q_r   <= 1'b1;
      end else if (fall[IN_OFF_TRIG]) begin
         off_pre_r <= '0;
         off_cnt_r <= '0;
         off_run_r <= 1'b1;
         off_q_r   <= 1'b1;
      end else if (off_run_r && off_step) begin
         off_pre_r <= '0;
         off_cnt_r <= off_cnt_r + DLY_W'(1);
         if (off_cnt_r + DLY_W'(1) == off_dly_r) begin
            off_cnt_r <= '0;
            off_run_r <= 1'b0;
            off_q_r   <= 1'b0;
         end
      end else if (off_run_r && tick) begin
         off_pre_r <= off_pre_r + PRE_W'(1);
      end
   end

   // Toggle relay; starts low and clear beats trigger.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_q_r <= 1'b0;
      end else if (lvl_r[IN_TOG_CLR]) begin
         tog_q_r <= 1'b0;
      end else if (rise[IN_TOG_TRIG]) begin
         tog_q_r <= ~tog_q_r;
      end
   end

   // Real-time clock; a software write loads minute and weekday.
   logic hund_end, sec_end, min_end;
   assign hund_end = tick && hund_r == HUND_LAST;
   assign sec_end  = hund_end && sec_r == SEC_LAST;
   assign min_end  = sec_end && min_r == MIN_LAST;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hund_r    <= '0;
         sec_r     <= '0;
         min_r     <= '0;
         wday_r    <= '0;
         date_r    <= '0;
         min_evt_r <= 1'b0;
      end else begin
         min_evt_r <= sec_end || (wr_en && paddr == ADDR_TIME);
         if (wr_en && paddr == ADDR_DATE) begin
            date_r <= pwdata[15:0];
         end else if (min_end) begin
            date_r <= date_r + 16'h0001;
         end
         if (wr_en && paddr == ADDR_TIME) begin
            hund_r <= '0;
            sec_r  <= '0;
            min_r  <= (time_wr.minute > MIN_LAST) ? MIN_LAST : time_wr.minute;
            wday_r <= (time_wr.wday > WDAY_LAST) ? WDAY_LAST : time_wr.wday;
         end else if (tick) begin
            hund_r <= hund_end ? '0 : hund_r + 7'h01;
            if (hund_end) begin
               sec_r <= sec_end ? '0 : sec_r + 6'h01;
            end
            if (sec_end) begin
               min_r <= min_end ? '0 : min_r + 11'h001;
            end
            if (min_end) begin
               wday_r <= (wday_r == WDAY_LAST) ? '0 : wday_r + 3'h1;
            end
         end
      end
   end

   // Slot under scan and whether it fires on the current minute and day.
   slot_time_t cur_time;
   slot_day_t  cur_day;
   logic       day_ok, hit_on, hit_off;
   assign cur_time = slot_time_mem[scan_idx_r];
   assign cur_day  = slot_day_mem[scan_idx_r];
   assign day_ok   = ctrl_r.tod_week ?
                     (wday_r >= cur_day.wday_start && wday_r <= cur_day.wday_end) :
                     (date_r == cur_day.date);
   assign hit_on   = slot_vld_r[scan_idx_r] && cur_time.on_en && day_ok &&
                     cur_time.on_min == min_r;
   assign hit_off  = slot_vld_r[scan_idx_r] && cur_time.off_en && day_ok &&
                     cur_time.off_min == min_r;

   // Each new minute walks all slots in order; the output changes only at
   // a programmed on or off time and otherwise keeps its state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_r     <= SCAN_IDLE;
         scan_idx_r <= '0;
         tod_q_r    <= 1'b0;
      end else begin
         case (scan_r)
            SCAN_IDLE: begin
               if (min_evt_r) begin
                  scan_r     <= SCAN_RUN;
                  scan_idx_r <= '0;
               end
            end
            SCAN_RUN: begin
               if (hit_off) begin
                  tod_q_r <= 1'b0;
               end else if (hit_on) begin
                  tod_q_r <= 1'b1;
               end
               if (min_evt_r) begin
                  scan_idx_r <= '0;
               end else if (scan_idx_r == SLOT_LAST) begin
                  scan_r <= SCAN_IDLE;
               end else begin
                  scan_idx_r <= scan_idx_r + IDX_W'(1);
               end
            end
            default: begin
               scan_r <= SCAN_IDLE;
            end
         endcase
      end
   end

   // Block outputs.
   assign on_delay_q  = on_q_r;
   assign off_delay_q = off_q_r;
   assign toggle_q    = tog_q_r;
   assign tod_q       = tod_q_r;

endmodule : ctl_blocks

// >>> ctl_blocks_assertions.sv
module ctl_blocks_assertions
   import ctl_blocks_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       on_trig,
   input wire logic       off_trig,
   input wire logic       off_clr,
   input wire logic       tog_trig,
   input wire logic       tog_clr,
   input wire logic       on_delay_q,
   input wire logic       off_delay_q,
   input wire logic       toggle_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Input pins held steady long enough to pass the synchroniser.
   sequence tog_held_s;
      tog_clr [*6];
   endsequence
   sequence off_held_s;
      off_clr [*6];
   endsequence
   sequence tog_quiet_s;
      (!tog_clr && $stable(tog_trig)) [*8];
   endsequence

   // Every access completes with no wait state.
   pready_high_a: assert property (pready)
      else $error("pready low in a cycle");
   // An error answer marks exactly the accesses to unmapped addresses.
   slv_err_a: assert property (pslverr == (psel && penable &&
                               (paddr > ADDR_TBL_DAY || paddr[1:0] != 2'h0)))
      else $error("pslverr does not match the address decode");
   // A held toggle clear keeps the output low.
   tog_clear_a: assert property (tog_held_s |-> !toggle_q)
      else $error("toggle output high under clear");
   // A held off-delay clear keeps the output low.
   off_clear_a: assert property (off_held_s |-> !off_delay_q)
      else $error("off-delay output high under clear");
   // A low on-delay trigger forces the output low.
   on_low_a: assert property ((!on_trig) [*7] |-> !on_delay_q)
      else $error("on-delay output high with trigger low");
   // A high off-delay trigger without clear drives the output high.
   off_high_a: assert property ((off_trig && !off_clr) [*8] |-> off_delay_q)
      else $error("off-delay output low with trigger high");
   // With no trigger edge and no clear the toggle output holds.
   tog_quiet_a: assert property (tog_quiet_s |-> $stable(toggle_q))
      else $error("toggle output changed without a trigger edge");
   // The on-delay output only rises while the trigger has been held.
   on_rise_a: assert property ($rose(on_delay_q) |-> $past(on_trig, 5))
      else $error("on-delay output rose without a held trigger");
endmodule : ctl_blocks_assertions

bind ctl_blocks ctl_blocks_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .on_trig(on_trig),
   .off_trig(off_trig), .off_clr(off_clr), .tog_trig(tog_trig),
   .tog_clr(tog_clr), .on_delay_q(on_delay_q), .off_delay_q(off_delay_q),
   .toggle_q(toggle_q)
);

// >>> testbench.sv
module testbench
   import ctl_blocks_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic        pready, pslverr, err_v;
   logic        on_trig, off_trig, off_clr, tog_trig, tog_clr;
   logic        on_delay_q, off_delay_q, toggle_q, tod_q;
   logic [3:0]  q_v;
   logic [11:0] pre_v [3] = '{PRE_SEC, PRE_MIN, PRE_HOUR};
   int          n_fail = 0;
   int          num_checks = 0;
   int          step;

   ctl_blocks #(.TICK_CYCLES(TICK)) ctl_blocks_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .on_trig(on_trig),
      .off_trig(off_trig), .off_clr(off_clr), .tog_trig(tog_trig),
      .tog_clr(tog_clr), .on_delay_q(on_delay_q), .off_delay_q(off_delay_q),
      .toggle_q(toggle_q), .tod_q(tod_q)
   );

   // Outputs gathered as one vector: on, off, toggle, switch.
   assign q_v = {tod_q, toggle_q, off_delay_q, on_delay_q};

   // Clock of 10 ns.
   always #5 pclk = ~pclk;

   task automatic close_out();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // One APB transfer; read data and error are kept in rd_v and err_v.
   // A slave that never answers is left to the watchdog.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_v, exp);
   endtask : rd

   task automatic slot(input logic [6:0] i, input logic [31:0] t, input logic [31:0] d);
      apb(1'b1, ADDR_TBL_IDX, {25'h0, i});
      apb(1'b1, ADDR_TBL_TIME, t);
      apb(1'b1, ADDR_TBL_DAY, d);
   endtask : slot

   // Waits a bounded time for one output to reach a level, then compares.
   task automatic wait_q(input int b, input logic v, input int max);
      int n;
      n = 0;
      while (q_v[b] !== v && n < max) begin
         @(posedge pclk);
         n++;
      end
      chk(q_v[b], v);
   endtask : wait_q

   // Writes the time of day and checks the switch after its scan.
   task automatic set_time(input logic [31:0] t, input logic v);
      apb(1'b1, ADDR_TIME, t);
      cyc(150);
      chk(tod_q, v);
   endtask : set_time

   // Watchdog.
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      close_out();
   end

   // Main sequence.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      on_trig = 1'b0;
      off_trig = 1'b0;
      off_clr = 1'b0;
      tog_trig = 1'b0;
      tog_clr = 1'b0;
      cyc(5);
      presetn <= 1'b1;
      chk(q_v, 4'h0);
      for (int i = 0; i < 3; i++) begin
         tog_trig <= 1'b1;
         cyc(6);
         tog_trig <= 1'b0;
         cyc(6);
         chk(toggle_q, !i[0]);
      end
      tog_clr <= 1'b1;
      cyc(6);
      tog_trig <= 1'b1;
      cyc(6);
      tog_trig <= 1'b0;
      cyc(6);
      tog_clr <= 1'b0;
      cyc(8);
      chk(toggle_q, 1'b0);
      tog_trig <= 1'b1;
      cyc(8);
      chk(toggle_q, 1'b1);
      presetn <= 1'b0;
      cyc(5);
      chk(q_v, 4'h0);
      presetn <= 1'b1;
      tog_trig <= 1'b0;
      // Register reset values, refusals and clamping.
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_ON_DLY, 32'h1);
      rd(ADDR_OFF_DLY, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'hff);
      rd(ADDR_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      chk(err_v, 1'b1);
      apb(1'b1, ADDR_ON_DLY, 32'h0);
      rd(ADDR_ON_DLY, 32'h1);
      apb(1'b1, ADDR_ON_DLY, 32'h3fff);
      rd(ADDR_ON_DLY, {18'h0, DLY_MAX});
      // Time-of-day table in chronological order; on minute in [21:11].
      slot(7'h00, 32'hc0005014, 32'h0);
      slot(7'h01, 32'h8000f000, 32'h300000);
      slot(7'h02, 32'h40000028, 32'h0);
      slot(7'h03, 32'h40000032, 32'h180000);
      apb(1'b1, ADDR_TBL_IDX, 32'h7f);
      rd(ADDR_TBL_TIME, 32'h0);
      set_time(32'd10, 1'b1);
      set_time(32'd15, 1'b1);
      set_time(32'd20, 1'b0);
      set_time(32'd30, 1'b1);
      set_time(32'd40, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h10);
      set_time(32'h4001e, 1'b1);
      set_time(32'h40032, 1'b1);
      set_time(32'h10032, 1'b0);
      // Off-delay with restart and clear, unit seconds.
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_OFF_DLY, 32'd5);
      off_trig <= 1'b1;
      wait_q(1, 1'b1, 8);
      cyc(4);
      off_trig <= 1'b0;
      cyc(12);
      chk(off_delay_q, 1'b1);
      off_trig <= 1'b1;
      cyc(4);
      off_trig <= 1'b0;
      cyc(16);
      chk(off_delay_q, 1'b1);
      wait_q(1, 1'b0, 30);
      off_trig <= 1'b1;
      cyc(8);
      off_clr <= 1'b1;
      cyc(8);
      chk(off_delay_q, 1'b0);
      off_clr <= 1'b0;
      wait_q(1, 1'b1, 12);
      off_trig <= 1'b0;
      wait_q(1, 1'b0, 40);
      // On-delay abandoned by a short drop, then completed.
      apb(1'b1, ADDR_ON_DLY, 32'd5);
      on_trig <= 1'b1;
      cyc(12);
      on_trig <= 1'b0;
      cyc(6);
      on_trig <= 1'b1;
      cyc(14);
      chk(on_delay_q, 1'b0);
      wait_q(0, 1'b1, 30);
      rd(ADDR_STATUS, 32'h41);
      on_trig <= 1'b0;
      wait_q(0, 1'b0, 8);
      // Two steps of each time unit.
      apb(1'b1, ADDR_ON_DLY, 32'd2);
      for (int u = 0; u < 3; u++) begin
         apb(1'b1, ADDR_CTRL, u);
         step = int'(pre_v[u]) * TICK;
         on_trig <= 1'b1;
         cyc(step);
         chk(on_delay_q, 1'b0);
         wait_q(0, 1'b1, step + 20);
         on_trig <= 1'b0;
         wait_q(0, 1'b0, 8);
      end
      close_out();
   end
endmodule : testbench
